/* hw/dpd_pkg.sv */
package dpd_pkg;
   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  PARAM_WORD_OFFSET = 8'h34; // parameter word
   localparam logic [7:0]  STATUS_OFFSET     = 8'h00; // status mirror
   localparam logic [7:0]  CONTROL_OFFSET    = 8'h04; // busy control
   localparam logic [31:0] PARAM_WORD_RESET  = 32'h5CD5BDF7;
   // ---------------------------------------------------------------
   // parameter word fields
   // ---------------------------------------------------------------
   localparam int          DPD_SUPPORT_POS   = 31;
   localparam logic [0:0]  DPD_SUPPORTED     = 1'h0; // zero = supported
   localparam int          ENTER_OP_LSB      = 23;
   localparam int          EXIT_OP_LSB       = 15;
   localparam int          UNIT_LSB          = 13;
   localparam int          COUNT_LSB         = 8;
   localparam int          RSVD_HI_LSB       = 4;
   localparam int          POLL_LSB          = 2;
   localparam logic [1:0]  WAKE_UNIT_1US     = 2'h1;
   localparam logic [4:0]  WAKE_COUNT        = 5'h1D;
   localparam logic [3:0]  RSVD_HI_VALUE     = 4'hF;
   localparam logic [1:0]  POLL_LEGACY       = 2'h1;
   localparam logic [1:0]  RSVD_LO_VALUE     = 2'h3;
   // ---------------------------------------------------------------
   // opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0]  OP_ENTER_DPD      = 8'hB9;
   localparam logic [7:0]  OP_EXIT_DPD       = 8'hAB;
   localparam logic [7:0]  OP_READ_STATUS    = 8'h05;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int          CLK_PERIOD_NS     = 40;
   localparam int          WAKE_UNIT_NS      = 1000;
   localparam int          WAKE_TIME_NS      =
      (int'(WAKE_COUNT) + 1) * WAKE_UNIT_NS;           // 30 us
   localparam int          WAKE_CYCLES       =
      (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'h1,
      ST_DPD    = 3'h2,
      ST_WAKE   = 3'h4
   } pwr_state_type;
endpackage

/* hw/spi_rx_if.sv */
`timescale 1ns/1ns
interface spi_rx_if;
   logic       sck_rise;   // sampled clock rising edge
   logic       sck_fall;   // sampled clock falling edge
   logic       cs_active;  // chip select asserted, synced
   logic       mosi;       // synced data in
   logic       byte_valid; // one-cycle pulse, byte complete
   logic [7:0] byte_data;  // received byte
   logic       first_byte; // byte is the opcode of a frame
   modport front (output sck_rise, sck_fall, cs_active, mosi);
   modport shift (input sck_rise, sck_fall, cs_active, mosi,
                  output byte_valid, byte_data, first_byte);
   modport core  (input sck_rise, sck_fall, cs_active,
                  byte_valid, byte_data, first_byte);
endinterface

/* hw/spi_sync.sv */
`timescale 1ns/1ns
module spi_sync
   import dpd_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic sck,
   input  wire logic ncs,
   input  wire logic mosi,
   spi_rx_if.front   rx
);
   // ---------------------------------------------------------------
   // two-stage synchronisers, third stage for edge finding
   // ---------------------------------------------------------------
   logic [2:0] sck_q;  // [0] meta, [1] stable, [2] previous
   logic [1:0] ncs_q;  // [0] meta, [1] stable
   logic [1:0] mosi_q; // [0] meta, [1] stable

   // edges only ever look at stages two and three
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sck_q  <= 3'h0;
         ncs_q  <= 2'h3;
         mosi_q <= 2'h0;
      end else begin
         sck_q  <= {sck_q[1:0], sck};
         ncs_q  <= {ncs_q[0], ncs};
         mosi_q <= {mosi_q[0], mosi};
      end
   end

   assign rx.sck_rise  = sck_q[1] & ~sck_q[2];
   assign rx.sck_fall  = ~sck_q[1] & sck_q[2];
   assign rx.cs_active = ~ncs_q[1];
   assign rx.mosi      = mosi_q[1];
endmodule

/* hw/spi_byte_rx.sv */
`timescale 1ns/1ns
module spi_byte_rx
   import dpd_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic nrst,
   spi_rx_if.shift   rx
);
   // ---------------------------------------------------------------
   // mode 0/3 shifter: sample on rising sck, msb first
   // ---------------------------------------------------------------
   logic [6:0] shift;     // partial byte
   logic [2:0] bit_cnt;   // bits held
   logic       got_first; // opcode already delivered this frame
   logic       last_bit;  // eighth bit arrives now

   assign last_bit = rx.cs_active & rx.sck_rise & (bit_cnt == 3'h7);

   // frame restart clears the count so bytes stay aligned
   always_ff @(posedge clk_sys) begin
      if (!nrst || !rx.cs_active) begin
         shift     <= 7'h00;
         bit_cnt   <= 3'h0;
         got_first <= 1'b0;
      end else if (rx.sck_rise) begin
         shift     <= {shift[5:0], rx.mosi};
         bit_cnt   <= bit_cnt + 3'h1;
         if (last_bit) got_first <= 1'b1;
      end
   end

   // byte output register
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rx.byte_valid <= 1'b0;
         rx.byte_data  <= 8'h00;
         rx.first_byte <= 1'b0;
      end else begin
         rx.byte_valid <= last_bit;
         if (last_bit) begin
            rx.byte_data  <= {shift, rx.mosi};
            rx.first_byte <= ~got_first;
         end
      end
   end
endmodule

/* hw/dpd_core.sv */
`timescale 1ns/1ns
module dpd_core
   import dpd_pkg::*;
#(
   parameter int WAKE_CNT = WAKE_CYCLES  // wake-up delay in clocks
)(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        sck,
   input  wire logic        ncs,
   input  wire logic        mosi,
   output logic             miso,
   output logic             miso_oe_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic             deep_power_down
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   // the countdown is sixteen bits wide, and a delay shorter than
   // eight clocks would be hidden by the sync lag of the link
   if (WAKE_CNT < 8 || WAKE_CNT > 65535) begin : g_bad_wake
      $error("WAKE_CNT out of range");
   end

   // ---------------------------------------------------------------
   // link front end
   // ---------------------------------------------------------------
   spi_rx_if rx ();

   spi_sync u_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .sck     (sck),
      .ncs     (ncs),
      .mosi    (mosi),
      .rx      (rx)
   );

   spi_byte_rx u_rx (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .rx      (rx)
   );

   // ---------------------------------------------------------------
   // parameter word, fixed content
   // ---------------------------------------------------------------
   logic [31:0] param_word; // assembled from fields

   assign param_word = {
      DPD_SUPPORTED,
      OP_ENTER_DPD,
      OP_EXIT_DPD,
      WAKE_UNIT_1US,
      WAKE_COUNT,
      RSVD_HI_VALUE,
      POLL_LEGACY,
      RSVD_LO_VALUE
   };

   // ---------------------------------------------------------------
   // software busy control
   // ---------------------------------------------------------------
   logic        busy_flag_bit; // internal operation running
   logic [15:0] wake_cnt;      // wake-up countdown
   logic        wr_control;    // control register write

   // only bit 0 of the control word is kept; the rest reads zero
   assign wr_control = reg_wr & (reg_addr == CONTROL_OFFSET);

   // software models an internal operation by writing bit 0
   always_ff @(posedge clk_sys) begin
      if (!nrst) busy_flag_bit <= 1'b0;
      else if (wr_control) busy_flag_bit <= reg_wdata[0];
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   pwr_state_type state;        // power state
   pwr_state_type next_state;   // next power state
   logic          op_strobe;    // opcode byte arrived
   logic          is_enter;     // opcode is entry
   logic          is_exit;      // opcode is exit
   logic          is_status;    // opcode is status read
   logic          wake_done;    // delay elapsed

   // only the first byte of a frame is an opcode, so a data byte
   // that happens to equal an opcode never moves the power state
   assign op_strobe = rx.byte_valid & rx.first_byte;
   assign is_enter  = op_strobe & (rx.byte_data == OP_ENTER_DPD);
   assign is_exit   = op_strobe & (rx.byte_data == OP_EXIT_DPD);
   assign is_status = op_strobe & (rx.byte_data == OP_READ_STATUS);
   // ends one count early so the wake state lasts WAKE_CNT clocks
   assign wake_done = (wake_cnt == 16'h0001);

   // only the exit opcode is seen while powered down, and
   // nothing at all until the wake delay ends
   always_comb begin
      next_state = state;
      case (state)
         ST_ACTIVE: begin
            if (is_enter) next_state = ST_DPD;
         end
         ST_DPD: begin
            if (is_exit) next_state = ST_WAKE;
         end
         ST_WAKE: begin
            if (wake_done) next_state = ST_ACTIVE;
         end
         default: next_state = ST_ACTIVE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (!nrst) state <= ST_ACTIVE;
      else state <= next_state;
   end

   // wake countdown, loaded on exit opcode
   always_ff @(posedge clk_sys) begin
      if (!nrst) wake_cnt <= 16'h0000;
      else if (state == ST_DPD && is_exit)
         wake_cnt <= 16'(WAKE_CNT);
      else if (wake_cnt != 16'h0000)
         wake_cnt <= wake_cnt - 16'h0001;
   end

   // ---------------------------------------------------------------
   // status read: shift status byte out on falling sck
   // ---------------------------------------------------------------
   logic       status_mode; // frame is a status read
   logic [7:0] out_shift;   // outgoing bits, msb first
   logic [7:0] status_byte; // live status value

   // busy also covers the wake window; only the register status word shows it, as the link answers status in the active state only
   assign status_byte = {7'h00,
                         busy_flag_bit | (state == ST_WAKE)};

   // status only answered in the active state
   always_ff @(posedge clk_sys) begin
      if (!nrst || !rx.cs_active) status_mode <= 1'b0;
      else if (is_status && state == ST_ACTIVE)
         status_mode <= 1'b1;
   end

   // reload every byte so repeated reads track the flag
   always_ff @(posedge clk_sys) begin
      if (!nrst) out_shift <= 8'h00;
      else if (rx.byte_valid) out_shift <= status_byte;
      else if (rx.sck_fall && status_mode)
         out_shift <= {out_shift[6:0], 1'b0};
   end

   // output pin drive; enable low while driving
   // the line moves on the falling link edge, so the host's next
   // rising edge finds it settled even after the sync lag
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         miso      <= 1'b0;
         miso_oe_n <= 1'b1;
      end else begin
         miso_oe_n <= ~(status_mode & rx.cs_active);
         if (rx.sck_fall && status_mode) miso <= out_shift[7];
      end
   end

   // ---------------------------------------------------------------
   // register read port
   // ---------------------------------------------------------------
   logic [31:0] rd_mux; // selected read value

   // unmapped offsets read zero; the status word packs busy, then
   // power-down, then waking, from bit 0 up

   assign rd_mux =
      (reg_addr == PARAM_WORD_OFFSET) ? param_word :
      (reg_addr == STATUS_OFFSET)     ?
         {29'h0, state == ST_WAKE, state == ST_DPD, status_byte[0]} :
      (reg_addr == CONTROL_OFFSET)    ? {31'h0, busy_flag_bit} :
      32'h00000000;

   // read data valid one cycle after the strobe only
   always_ff @(posedge clk_sys) begin
      if (!nrst) reg_rdata <= 32'h00000000;
      else if (reg_rd) reg_rdata <= rd_mux;
      else reg_rdata <= 32'h00000000;
   end

   // power-down flag output
   always_ff @(posedge clk_sys) begin
      if (!nrst) deep_power_down <= 1'b0;
      else deep_power_down <= (next_state == ST_DPD);
   end

   // ---------------------------------------------------------------
   // checker helper: length of the last wake window
   // ---------------------------------------------------------------
   logic [15:0] wake_seen; // clocks spent in the wake state so far

   // a repetition cannot span the whole delay, so the wake window
   // is counted here and checked once, on the way out
   always_ff @(posedge clk_sys) begin
      if (!nrst) wake_seen <= 16'h0000;
      else if (state == ST_WAKE) wake_seen <= wake_seen + 16'h0001;
      else wake_seen <= 16'h0000;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // parameter word as software reads it
   a_param_const: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      reg_rd && reg_addr == PARAM_WORD_OFFSET |=> reg_rdata == 32'h5CD5BDF7)
      else $error("parameter word wrong");
   a_unit_field: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      reg_rd && reg_addr == PARAM_WORD_OFFSET |=>
         reg_rdata[14:13] == 2'h1 && reg_rdata[12:8] == 5'h1D)
      else $error("wake unit or count wrong");
   a_poll_field: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      reg_rd && reg_addr == PARAM_WORD_OFFSET |=> reg_rdata[3:2] == 2'h1)
      else $error("polling field wrong");
   a_rsvd_ones: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      reg_rd && reg_addr == PARAM_WORD_OFFSET |=>
         reg_rdata[7:4] == 4'hF && reg_rdata[1:0] == 2'h3)
      else $error("reserved bits not ones");

   // power state sequencing
   a_enter_dpd: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      state == ST_ACTIVE && is_enter |=> state == ST_DPD)
      else $error("entry opcode not taken");
   a_exit_dpd: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      state == ST_DPD && is_exit |=> state == ST_WAKE)
      else $error("exit opcode not taken");
   a_dpd_ignore: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      state == ST_DPD && !is_exit |=> state == ST_DPD)
      else $error("left power-down without exit");
   a_wake_hold: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      $rose(state == ST_WAKE) |-> (state == ST_WAKE)[*8])
      else $error("wake delay too short");
   a_wake_len: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      $fell(state == ST_WAKE) |-> wake_seen == 16'(WAKE_CNT))
      else $error("wake delay length wrong");

   // busy reporting and the status line
   a_busy_bit: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      reg_rd && reg_addr == STATUS_OFFSET && state == ST_WAKE |=>
         reg_rdata[0])
      else $error("busy clear during wake");
   a_ctrl_busy: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      wr_control |=> busy_flag_bit == $past(reg_wdata[0]))
      else $error("busy flag not written");
   a_dpd_silent: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      state != ST_ACTIVE |-> miso_oe_n)
      else $error("status answered outside active state");
   a_status_answer: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      is_status && state == ST_ACTIVE && rx.cs_active |=> status_mode)
      else $error("status opcode not answered");

   // read port idles at zero between reads
   a_rd_zero: assert property (@(posedge clk_sys)
      disable iff (!nrst)
      !reg_rd |=> reg_rdata == 32'h00000000)
      else $error("read data outside slot");

   // ---------------------------------------------------------------
   // coverage of the main scenarios
   // ---------------------------------------------------------------
   c_enter: cover property (@(posedge clk_sys) state == ST_DPD);
   c_wake:  cover property (@(posedge clk_sys)
      state == ST_WAKE ##1 state == ST_ACTIVE);
   c_status: cover property (@(posedge clk_sys) status_mode);
   c_status_busy: cover property (@(posedge clk_sys)
      status_mode && status_byte[0]);
   c_wake_ignored: cover property (@(posedge clk_sys)
      state == ST_WAKE && is_enter);
endmodule

/* bench/spi_host_model.sv */
`timescale 1ns/1ns
module spi_host_model
   import dpd_pkg::*;
(
   output logic      sck,
   output logic      ncs,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe_n
);
   // ---------------------------------------------------------------
   // link timing and line state
   // ---------------------------------------------------------------
   localparam int HALF_NS = 160;  // half of a 320 ns link period
   logic          prev_bit;       // last level seen on the return line
   logic          oe_seen;        // device drove the line this frame

   // clock idles low between frames, select idles high
   initial begin
      sck      = 1'b0;
      ncs      = 1'b1;
      mosi     = 1'b0;
      prev_bit = 1'b0;
      oe_seen  = 1'b0;
   end

   // one bit, mode 0: data set while low, read late in the high phase
   // so that a few clocks of sync lag in the device still fit
   task automatic bit_xfer(input logic tx, output logic rx);
      mosi = tx;
      #HALF_NS sck = 1'b1;
      #(HALF_NS - 10);
      // a released line shows the inverse of its last level
      rx = miso_oe_n ? ~prev_bit : miso;
      prev_bit = rx;
      if (!miso_oe_n) oe_seen = 1'b1;
      #10 sck = 1'b0;
   endtask

   // one whole frame: opcode msb first, optionally one byte back
   task automatic frame(input logic [7:0] op, input logic two,
                        output logic [7:0] rx);
      logic b;
      rx      = 8'h00;
      oe_seen = 1'b0;
      ncs     = 1'b0;
      #HALF_NS;
      for (int i = 7; i >= 0; i--) bit_xfer(op[i], b);
      if (two) for (int i = 7; i >= 0; i--) bit_xfer(1'b0, rx[i]);
      #HALF_NS ncs = 1'b1;
      // no stale data left on the line between frames
      mosi = ~mosi;
      // select stays high long enough to part two commands
      #(4 * HALF_NS);
   endtask

   // a command with no data phase (enter or leave power-down)
   task automatic command(input logic [7:0] op);
      logic [7:0] d;
      frame(op, 1'b0, d);
   endtask

   // busy polling through the status byte
   task automatic read_status(output logic [7:0] st, output logic drv);
      frame(OP_READ_STATUS, 1'b1, st);
      drv = oe_seen;
   endtask

   // host side of the exit delay: nothing sent until it has run out
   task automatic wake_wait;
      #(WAKE_TIME_NS);
   endtask
endmodule

/* bench/deep_power_down_and_busy_poll_tb_top.sv */
`timescale 1ns/1ns
module deep_power_down_and_busy_poll_tb_top
   import dpd_pkg::*;
;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   localparam int WAKE_SIM = 150;  // short wake so a frame fits in it
   logic          clk_sys;
   logic          nrst;
   logic          sck;
   logic          ncs;
   logic          mosi;
   logic          miso;
   logic          miso_oe_n;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata;
   logic          reg_wr;
   logic          reg_rd;
   logic [31:0]   reg_rdata;
   logic          deep_power_down;
   int            failures;
   int            num_checks;
   logic [31:0]   d;
   logic [7:0]    st;
   logic          drv;

   dpd_core #(.WAKE_CNT(WAKE_SIM)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .sck(sck), .ncs(ncs),
      .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .deep_power_down(deep_power_down));

   spi_host_model host (.sck(sck), .ncs(ncs), .mosi(mosi),
      .miso(miso), .miso_oe_n(miso_oe_n));

   // 25 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h",
                  $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // a hang is cut short well beyond the expected ~100 us
   initial begin
      #1000000;
      failures++;
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial begin
      failures   = 0;
      num_checks = 0;
      nrst       = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      repeat (11) @(posedge clk_sys);
      #1 check(32'(deep_power_down), 32'h0);
      check(32'(miso_oe_n), 32'h1);
      @(posedge clk_sys);
      nrst <= 1'b1;
      // parameter word, field by field
      reg_read(PARAM_WORD_OFFSET, d);
      check(32'(d[31]), 32'h0);
      check(32'(d[30:23]), 32'hB9);
      check(32'(d[22:15]), 32'hAB);
      check(32'(d[14:13]), 32'h1);
      check(32'(d[12:8]), 32'h1D);
      check(32'(d[7:4]), 32'hF);
      check(32'(d[3:2]), 32'h1);
      check(32'(d[1:0]), 32'h3);
      @(posedge clk_sys);
      #1 check(reg_rdata, 32'h0);
      // read-only word ignores writes, unmapped place reads zero
      reg_write(PARAM_WORD_OFFSET, 32'h0);
      reg_read(PARAM_WORD_OFFSET, d);
      check(d, 32'h5CD5BDF7);
      reg_read(8'hFC, d);
      check(d, 32'h0);
      // busy flag seen by software and by status polling
      reg_write(CONTROL_OFFSET, 32'h1);
      reg_read(CONTROL_OFFSET, d);
      check(d, 32'h1);
      reg_read(STATUS_OFFSET, d);
      check(32'(d[0]), 32'h1);
      host.read_status(st, drv);
      check(32'(st), 32'h1);
      check(32'(drv), 32'h1);
      check(32'(miso_oe_n), 32'h1);
      reg_write(CONTROL_OFFSET, 32'h0);
      host.read_status(st, drv);
      check(32'(st[0]), 32'h0);
      // enter power-down; a status read is not answered there
      host.command(OP_ENTER_DPD);
      check(32'(deep_power_down), 32'h1);
      reg_read(STATUS_OFFSET, d);
      check(32'(d[2:0]), 32'h2);
      host.read_status(st, drv);
      check(32'(drv), 32'h0);
      // exit, then a command during the wake delay is ignored
      host.command(OP_EXIT_DPD);
      check(32'(deep_power_down), 32'h0);
      reg_read(STATUS_OFFSET, d);
      check(32'(d[2:0]), 32'h5);
      host.command(OP_ENTER_DPD);
      check(32'(deep_power_down), 32'h0);
      host.wake_wait();
      reg_read(STATUS_OFFSET, d);
      check(32'(d[2:0]), 32'h0);
      host.read_status(st, drv);
      check(32'(st[0]), 32'h0);
      check(32'(drv), 32'h1);
      // decoding has resumed: a second full cycle
      host.command(OP_ENTER_DPD);
      check(32'(deep_power_down), 32'h1);
      host.command(OP_EXIT_DPD);
      host.wake_wait();
      check(32'(deep_power_down), 32'h0);
      report_and_stop();
   end
endmodule
